// [jtag_idcode_consts.svh]
// constants for the boundary-scan instruction and identification logic
// assumes inclusion by bare name before any module that uses it
// Contract
// R1 - read-only 32-bit identification register via IDCODE
// R2 - maker bits 11:1, revision 31:28, bit0 one
// R3 - part field bits 27:12 per depth variant
// R4 - instruction register is four bits wide
// R5 - instruction bits shift only in Shift-IR
// R6 - current instruction picks the serial data path
// R7 - unselected data registers stay undisturbed
// R8 - code 0x00 external test, boundary register
// R9 - code 0x01 sample, chip stays functional
// R10 - sample/preload also preloads boundary register
// R11 - code 0x02 selects identification register
// R12 - identification read leaves chip operation alone
// R13 - identification readable after power-up or reset
// R14 - code 0x03 disables all outputs, bypass path
// R15 - bypass shifting keeps outputs disabled
// R16 - code 0x0F bypass, normal function
// R17 - bypass stage cleared in Capture-DR
// R18 - Capture-IR loads pattern ending in 01
// R19 - Update-IR latches instruction on falling edge
// R20 - controller resets via TRST or five TMS-high
// R21 - unlisted codes act as bypass
// R22 - identification instruction current after test reset
`ifndef JTAG_IDCODE_CONSTS_SVH
`define JTAG_IDCODE_CONSTS_SVH

// ==========================================
// instruction codes
`define IR_WIDTH        4
`define INSTR_EXTEST    4'h0
`define INSTR_SAMPLE    4'h1
`define INSTR_IDCODE    4'h2
`define INSTR_HIGHZ     4'h3
`define INSTR_BYPASS    4'hF
`define IR_CAPTURE      4'h5
`define IR_RESET_VALUE  `INSTR_IDCODE

// ==========================================
// identification word layout
`define ID_WIDTH        32
`define ID_VER_MSB      31
`define ID_VER_LSB      28
`define ID_PART_MSB     27
`define ID_PART_LSB     12
`define ID_MAKER_MSB    11
`define ID_MAKER_LSB    1
`define ID_MARKER_BIT   0
`define ID_MARKER_VALUE 1'b1
// arbitrary neutral identity values
`define ID_DEF_VERSION  4'h1
`define ID_DEF_PART     16'h5A5A
`define ID_DEF_MAKER    11'h155

// ==========================================
// data registers and reset values
`define BSR_DEF_LEN     8
`define BYPASS_CAPTURE  1'b0
`define SYNC_STAGES     2

`endif

// [jtag_types_pkg.sv]
// types shared by the boundary-scan logic
// assumes nothing of its surroundings
package jtag_types_pkg;

    // ==========================================
    // test-port controller states
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_t;

    // ==========================================
    // serial data path selection
    typedef enum logic [1:0] {
        DR_BOUNDARY,
        DR_IDENT,
        DR_BYPASS
    } dr_sel_t;

endpackage : jtag_types_pkg

// [pin_sync.sv]
// two-stage synchroniser for signals from outside the clk domain
// assumes ce freezes state and reset_n is asynchronous active low
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);

    // ==========================================
    // stages: first one is read only by the second
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            q      <= '0;
        end else if (ce) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : pin_sync

`default_nettype wire

// [jtag_instruction_idcode_logic.sv]
// boundary-scan controller, instruction register and data path select
// assumes tck, tms, tdi, trst_n and sys_in come from pins; clk oversamples tck
`timescale 1ns/10ps
`default_nettype none
`include "jtag_idcode_consts.svh"

module jtag_instruction_idcode_logic #(
    parameter int unsigned    BSR_LEN     = `BSR_DEF_LEN,
    parameter logic [3:0]     ID_VERSION  = `ID_DEF_VERSION,
    parameter logic [15:0]    ID_PART     = `ID_DEF_PART,
    parameter logic [10:0]    ID_MAKER    = `ID_DEF_MAKER
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 ce,
    input  wire logic                 tck,
    input  wire logic                 tms,
    input  wire logic                 tdi,
    input  wire logic                 trst_n,
    input  wire logic [BSR_LEN-1:0]   sys_in,
    output var  logic                 tdo,
    output var  logic                 tdo_oe,
    output var  logic [BSR_LEN-1:0]   bs_drive,
    output var  logic                 extest_mode,
    output var  logic                 outputs_hiz,
    output var  logic [3:0]           instr_now,
    output var  logic                 test_reset_state
);

    // ==========================================
    // functions
    function automatic jtag_types_pkg::tap_state_t tap_next(
        input jtag_types_pkg::tap_state_t st,
        input logic                       m
    );
        jtag_types_pkg::tap_state_t nx;
        nx = st;
        case (st)
            jtag_types_pkg::TEST_LOGIC_RESET: begin
                nx = m ? jtag_types_pkg::TEST_LOGIC_RESET : jtag_types_pkg::RUN_TEST_IDLE;
            end
            jtag_types_pkg::RUN_TEST_IDLE: begin
                nx = m ? jtag_types_pkg::SELECT_DR : jtag_types_pkg::RUN_TEST_IDLE;
            end
            jtag_types_pkg::SELECT_DR: begin
                nx = m ? jtag_types_pkg::SELECT_IR : jtag_types_pkg::CAPTURE_DR;
            end
            jtag_types_pkg::CAPTURE_DR: begin
                nx = m ? jtag_types_pkg::EXIT1_DR : jtag_types_pkg::SHIFT_DR;
            end
            jtag_types_pkg::SHIFT_DR: begin
                nx = m ? jtag_types_pkg::EXIT1_DR : jtag_types_pkg::SHIFT_DR;
            end
            jtag_types_pkg::EXIT1_DR: begin
                nx = m ? jtag_types_pkg::UPDATE_DR : jtag_types_pkg::PAUSE_DR;
            end
            jtag_types_pkg::PAUSE_DR: begin
                nx = m ? jtag_types_pkg::EXIT2_DR : jtag_types_pkg::PAUSE_DR;
            end
            jtag_types_pkg::EXIT2_DR: begin
                nx = m ? jtag_types_pkg::UPDATE_DR : jtag_types_pkg::SHIFT_DR;
            end
            jtag_types_pkg::UPDATE_DR: begin
                nx = m ? jtag_types_pkg::SELECT_DR : jtag_types_pkg::RUN_TEST_IDLE;
            end
            jtag_types_pkg::SELECT_IR: begin
                nx = m ? jtag_types_pkg::TEST_LOGIC_RESET : jtag_types_pkg::CAPTURE_IR;
            end
            jtag_types_pkg::CAPTURE_IR: begin
                nx = m ? jtag_types_pkg::EXIT1_IR : jtag_types_pkg::SHIFT_IR;
            end
            jtag_types_pkg::SHIFT_IR: begin
                nx = m ? jtag_types_pkg::EXIT1_IR : jtag_types_pkg::SHIFT_IR;
            end
            jtag_types_pkg::EXIT1_IR: begin
                nx = m ? jtag_types_pkg::UPDATE_IR : jtag_types_pkg::PAUSE_IR;
            end
            jtag_types_pkg::PAUSE_IR: begin
                nx = m ? jtag_types_pkg::EXIT2_IR : jtag_types_pkg::PAUSE_IR;
            end
            jtag_types_pkg::EXIT2_IR: begin
                nx = m ? jtag_types_pkg::UPDATE_IR : jtag_types_pkg::SHIFT_IR;
            end
            jtag_types_pkg::UPDATE_IR: begin
                nx = m ? jtag_types_pkg::SELECT_DR : jtag_types_pkg::RUN_TEST_IDLE;
            end
            default: begin
                nx = jtag_types_pkg::TEST_LOGIC_RESET;
            end
        endcase
        return nx;
    endfunction : tap_next

    // instruction to data path decode
    function automatic jtag_types_pkg::dr_sel_t path_of(input logic [3:0] ins);
        jtag_types_pkg::dr_sel_t sel;
        case (ins)
            `INSTR_EXTEST: sel = jtag_types_pkg::DR_BOUNDARY;
            `INSTR_SAMPLE: sel = jtag_types_pkg::DR_BOUNDARY;
            `INSTR_IDCODE: sel = jtag_types_pkg::DR_IDENT;
            `INSTR_HIGHZ:  sel = jtag_types_pkg::DR_BYPASS;
            default:       sel = jtag_types_pkg::DR_BYPASS;
        endcase
        return sel;
    endfunction : path_of

    // ==========================================
    // pin synchronisers
    logic [3:0]         pins_s;
    logic [BSR_LEN-1:0] sys_s;

    pin_sync #(
        .WIDTH   (4)
    ) u_pin_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .d       ({trst_n, tdi, tms, tck}),
        .q       (pins_s)
    );

    pin_sync #(
        .WIDTH   (BSR_LEN)
    ) u_sys_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .d       (sys_in),
        .q       (sys_s)
    );

    wire logic tck_s     = pins_s[0];
    wire logic tms_s     = pins_s[1];
    wire logic tdi_s     = pins_s[2];
    wire logic trst_n_s  = pins_s[3];

    // ==========================================
    // tck edge detection
    // reset low matches the idle level of tck, so no false edge after reset
    logic tck_d_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tck_d_q <= 1'b0;
        end else if (ce) begin
            tck_d_q <= tck_s;
        end
    end

    wire logic tck_rise = tck_s & ~tck_d_q;
    wire logic tck_fall = ~tck_s & tck_d_q;

    // ==========================================
    // controller state
    jtag_types_pkg::tap_state_t state_q;
    jtag_types_pkg::tap_state_t state_d;

    assign state_d = tap_next(state_q, tms_s);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= jtag_types_pkg::TEST_LOGIC_RESET;
        end else if (ce) begin
            if (!trst_n_s) begin
                state_q <= jtag_types_pkg::TEST_LOGIC_RESET; // R20
            end else if (tck_rise) begin
                state_q <= state_d; // R20
            end
        end
    end

    wire logic st_reset   = (state_q == jtag_types_pkg::TEST_LOGIC_RESET);
    wire logic st_cap_ir  = (state_q == jtag_types_pkg::CAPTURE_IR);
    wire logic st_sh_ir   = (state_q == jtag_types_pkg::SHIFT_IR);
    wire logic st_upd_ir  = (state_q == jtag_types_pkg::UPDATE_IR);
    wire logic st_cap_dr  = (state_q == jtag_types_pkg::CAPTURE_DR);
    wire logic st_sh_dr   = (state_q == jtag_types_pkg::SHIFT_DR);
    wire logic st_upd_dr  = (state_q == jtag_types_pkg::UPDATE_DR);
    wire logic tap_active = trst_n_s;

    // ==========================================
    // tck-qualified strobes shared by the scan registers
    // tms and tdi ride the same two stages as tck, so they are settled here
    wire logic tap_rise = ce & tap_active & tck_rise;
    wire logic tap_fall = ce & tap_active & tck_fall;

    // ==========================================
    // instruction register
    logic [`IR_WIDTH-1:0] ir_shift_q; // R4
    logic [`IR_WIDTH-1:0] ir_hold_q;
    // hold stage moves only on the fall in update or in test reset, so an aborted scan keeps the instruction

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ir_shift_q <= `IR_CAPTURE;
        end else if (tap_rise) begin
            if (st_cap_ir) begin
                ir_shift_q <= `IR_CAPTURE; // R18
            end else if (st_sh_ir) begin
                ir_shift_q <= {tdi_s, ir_shift_q[`IR_WIDTH-1:1]}; // R5
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ir_hold_q <= `IR_RESET_VALUE; // R13
        end else if (ce) begin
            if (!trst_n_s || st_reset) begin
                ir_hold_q <= `IR_RESET_VALUE; // R22
            end else if (tck_fall && st_upd_ir) begin
                ir_hold_q <= ir_shift_q; // R19
            end
        end
    end

    // ==========================================
    // instruction decode
    jtag_types_pkg::dr_sel_t dr_sel;

    // unlisted codes fall through to the bypass path
    assign dr_sel = path_of(ir_hold_q); // R6 R21

    wire logic sel_bsr    = (dr_sel == jtag_types_pkg::DR_BOUNDARY);
    wire logic sel_ident  = (dr_sel == jtag_types_pkg::DR_IDENT); // R11
    wire logic sel_bypass = (dr_sel == jtag_types_pkg::DR_BYPASS); // R16
    wire logic is_extest  = (ir_hold_q == `INSTR_EXTEST); // R8
    wire logic is_sample  = (ir_hold_q == `INSTR_SAMPLE); // R9
    wire logic is_highz   = (ir_hold_q == `INSTR_HIGHZ); // R14

    // ==========================================
    // identification register
    wire logic [`ID_WIDTH-1:0] id_word;

    assign id_word[`ID_VER_MSB:`ID_VER_LSB]     = ID_VERSION; // R2
    assign id_word[`ID_PART_MSB:`ID_PART_LSB]   = ID_PART; // R3
    assign id_word[`ID_MAKER_MSB:`ID_MAKER_LSB] = ID_MAKER; // R2
    assign id_word[`ID_MARKER_BIT]              = `ID_MARKER_VALUE; // R2

    logic [`ID_WIDTH-1:0] id_shift_q; // R1
    // capture reloads the fixed word, so shifted-in bits never stick

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            id_shift_q <= '0;
        end else if (tap_rise && sel_ident) begin // R7
            if (st_cap_dr) begin
                id_shift_q <= id_word; // R1 R12
            end else if (st_sh_dr) begin
                id_shift_q <= {tdi_s, id_shift_q[`ID_WIDTH-1:1]};
            end
        end
    end

    // ==========================================
    // bypass register
    logic bypass_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bypass_q <= `BYPASS_CAPTURE;
        end else if (tap_rise && sel_bypass) begin // R7
            if (st_cap_dr) begin
                bypass_q <= `BYPASS_CAPTURE; // R17
            end else if (st_sh_dr) begin
                bypass_q <= tdi_s; // R15 R16
            end
        end
    end

    // ==========================================
    // boundary-scan register
    logic [BSR_LEN-1:0] bsr_shift_q;
    logic [BSR_LEN-1:0] bsr_update_q;
    // update latch holds what the pads drive under external test

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bsr_shift_q <= '0;
        end else if (tap_rise && sel_bsr) begin // R7
            if (st_cap_dr) begin
                bsr_shift_q <= sys_s; // R9
            end else if (st_sh_dr) begin
                bsr_shift_q <= {tdi_s, bsr_shift_q[BSR_LEN-1:1]};
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bsr_update_q <= '0;
        end else if (tap_fall && st_upd_dr) begin
            if (is_extest || is_sample) begin
                bsr_update_q <= bsr_shift_q; // R10
            end
        end
    end

    // ==========================================
    // serial output
    wire logic ser_dr = sel_ident ? id_shift_q[0]
                      : sel_bsr   ? bsr_shift_q[0]
                      : bypass_q;
    wire logic ser_out  = st_sh_ir ? ir_shift_q[0] : ser_dr; // R6
    wire logic shifting = st_sh_ir | st_sh_dr;
    // tdo moves on the fall so the controller samples it settled at its next rise

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (ce) begin
            if (!tap_active) begin
                tdo    <= 1'b0;
                tdo_oe <= 1'b0;
            end else if (tck_fall) begin
                tdo    <= shifting ? ser_out : 1'b0;
                tdo_oe <= shifting;
            end
        end
    end

    // ==========================================
    // chip-facing controls
    // registered so every pin-facing output leaves a flop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bs_drive         <= '0;
            extest_mode      <= 1'b0;
            outputs_hiz      <= 1'b0;
            instr_now        <= `IR_RESET_VALUE;
            test_reset_state <= 1'b1;
        end else if (ce) begin
            bs_drive         <= bsr_update_q; // R8
            extest_mode      <= is_extest; // R8
            outputs_hiz      <= is_highz; // R14 R15
            instr_now        <= ir_hold_q;
            test_reset_state <= st_reset;
        end
    end

endmodule : jtag_instruction_idcode_logic

`default_nettype wire

// [jtag_port_checker.sv]
// concurrent checks on the ports of the instruction and identification logic
// assumes binding into the top module, with its BSR_LEN handed on
`timescale 1ns/10ps
`default_nettype none

module jtag_port_checker #(
    parameter int unsigned BSR_LEN = 8
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               trst_n,
    input  wire logic               tdo,
    input  wire logic               tdo_oe,
    input  wire logic [BSR_LEN-1:0] bs_drive,
    input  wire logic               extest_mode,
    input  wire logic               outputs_hiz,
    input  wire logic [3:0]         instr_now,
    input  wire logic               test_reset_state
);
    // ==========================================
    // timing
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ==========================================
    // properties
    a_extest_decode: assert property (extest_mode == (instr_now == 4'h0))
        else $error("extest flag disagrees with instruction");
    a_hiz_decode: assert property (outputs_hiz == (instr_now == 4'h3))
        else $error("high impedance flag disagrees with instruction");
    a_reset_values: assert property ($rose(reset_n) |-> instr_now == 4'h2 && test_reset_state && !tdo_oe)
        else $error("wrong state after reset");
    a_trst_resets: assert property (!trst_n [*5] |-> test_reset_state && instr_now == 4'h2 && !tdo_oe)
        else $error("test reset pin ignored");
    a_tlr_idcode: assert property (test_reset_state [*3] |-> instr_now == 4'h2)
        else $error("identification not current in reset state");
    a_instr_no_shift: assert property ($changed(instr_now) && instr_now != 4'h2 |-> !tdo_oe)
        else $error("instruction changed while shifting");
    a_bs_only_bsr: assert property ($changed(bs_drive) |-> $past(instr_now) inside {4'h0, 4'h1})
        else $error("boundary latch changed while unselected");
    a_idle_tdo: assert property (!tdo_oe |-> !tdo)
        else $error("serial out active outside shift");
endmodule : jtag_port_checker

bind jtag_instruction_idcode_logic jtag_port_checker #(.BSR_LEN(BSR_LEN)) i_jtag_port_checker (
    .clk, .reset_n, .trst_n, .tdo, .tdo_oe, .bs_drive, .extest_mode, .outputs_hiz, .instr_now, .test_reset_state
);
`default_nettype wire

// [tap_master.sv]
// test controller model driving the test port pins
// assumes clk is the 4 ns system clock; one tck period is eight clk
`timescale 1ns/10ps
`default_nettype none

module tap_master (
    input  wire logic clk,
    input  wire logic tdo,
    output var  logic tck,
    output var  logic tms,
    output var  logic tdi,
    output var  logic trst_n
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end

    // ==========================================
    // one tck period, serial out taken before the fall
    task automatic pulse(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        tck = 1'b1;
        repeat (4) @(negedge clk);
        o = tdo;
        tck = 1'b0;
    endtask : pulse

    // state step with junk on the data line
    task automatic nav(input logic m);
        logic o;
        pulse(m, ~tdi, o);
    endtask : nav

    // ==========================================
    // resets
    task automatic tlr();
        repeat (5) nav(1'b1);
        nav(1'b0);
    endtask : tlr

    task automatic hard_reset();
        trst_n = 1'b0;
        repeat (16) @(negedge clk);
        trst_n = 1'b1;
        repeat (16) @(negedge clk);
    endtask : hard_reset

    // ==========================================
    // scan n bits lsb first from idle back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        nav(1'b1);
        if (ir) begin
            nav(1'b1);
        end
        nav(1'b0);
        nav(1'b0);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], dout[i]);
        end
        nav(1'b1);
        nav(1'b0);
    endtask : scan
endmodule : tap_master
`default_nettype wire

// [tb.sv]
// self-checking bench for the instruction and identification logic
// assumes the checker and the controller model are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "jtag_idcode_consts.svh"

module tb;
    localparam logic [3:0]  VER  = 4'h9;     // arbitrary
    localparam logic [15:0] PART = 16'h3C96; // arbitrary
    localparam logic [10:0] MAKR = 11'h2A7;  // arbitrary
    localparam logic [31:0] IDW  = {VER, PART, MAKR, `ID_MARKER_VALUE};

    // path: 0 boundary, 1 identification, 2 bypass
    typedef struct packed {
        logic [3:0] code;
        logic [1:0] path;
        logic       ext;
        logic       hiz;
    } row_t;

    logic        clk;
    logic        reset_n;
    logic        tck, tms, tdi, trst_n;
    logic        tdo, tdo_oe, extest_mode, outputs_hiz, test_reset_state;
    logic [7:0]  sys_in, bs_drive, pat, bsx, want;
    logic [3:0]  instr_now;
    logic [31:0] got;
    int          failures, n_checks;
    row_t        r;
    row_t        rows [9] = '{'{4'h0, 2'h0, 1'b1, 1'b0}, '{4'h1, 2'h0, 1'b0, 1'b0}, '{4'h2, 2'h1, 1'b0, 1'b0},
                              '{4'h3, 2'h2, 1'b0, 1'b1}, '{4'hF, 2'h2, 1'b0, 1'b0}, '{4'h4, 2'h2, 1'b0, 1'b0},
                              '{4'h7, 2'h2, 1'b0, 1'b0}, '{4'h9, 2'h2, 1'b0, 1'b0}, '{4'hE, 2'h2, 1'b0, 1'b0}};

    jtag_instruction_idcode_logic #(.BSR_LEN(8), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKR))
        i_jtag_instruction_idcode_logic (.clk, .reset_n, .ce(1'b1), .tck, .tms, .tdi, .trst_n, .sys_in, .tdo,
        .tdo_oe, .bs_drive, .extest_mode, .outputs_hiz, .instr_now, .test_reset_state);
    tap_master i_tap_master (.clk, .tdo, .tck, .tms, .tdi, .trst_n);

    // ==========================================
    // clock and helpers
    initial clk = 1'b0;
    always #2 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        if (failures == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    task automatic read_id();
        i_tap_master.scan(1'b0, 32, ~IDW, got);
        check(got, IDW);
    endtask : read_id

    initial begin
        #100us;
        failures++;
        conclude();
    end

    // ==========================================
    // main sequence
    initial begin
        reset_n = 1'b0;
        sys_in = 8'h00;
        bsx = 8'h00;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        check(instr_now, `INSTR_IDCODE);
        check(test_reset_state, 1'b1);
        check(bs_drive, 8'h00);
        i_tap_master.nav(1'b0);
        read_id();
        read_id();
        check(extest_mode | outputs_hiz, 1'b0);
        foreach (rows[k]) begin
            r = rows[k];
            pat = 8'h5A ^ {r.code, ~r.code};
            @(negedge clk) sys_in = {~r.code, r.code};
            i_tap_master.scan(1'b1, 4, {28'h0, r.code}, got);
            check(got[1:0], 2'b01);
            check(instr_now, r.code);
            check(extest_mode, r.ext);
            check(outputs_hiz, r.hiz);
            i_tap_master.scan(1'b0, 8, {24'h0, pat}, got);
            want = r.path == 2'h0 ? sys_in : (r.path == 2'h1 ? IDW[7:0] : {pat[6:0], 1'b0});
            if (r.path == 2'h0) begin
                bsx = pat;
            end
            check(got[7:0], want);
            check(bs_drive, bsx);
            check(outputs_hiz, r.hiz);
        end
        i_tap_master.tlr();
        check(instr_now, `INSTR_IDCODE);
        read_id();
        i_tap_master.scan(1'b1, 4, {28'h0, `INSTR_BYPASS}, got);
        i_tap_master.hard_reset();
        check(test_reset_state, 1'b1);
        check(instr_now, `INSTR_IDCODE);
        i_tap_master.nav(1'b0);
        read_id();
        i_tap_master.nav(1'b1);
        i_tap_master.nav(1'b0);
        i_tap_master.nav(1'b0);
        repeat (4) @(negedge clk);
        check({tdo_oe, tdo}, 2'b11);
        i_tap_master.tlr();
        check({tdo_oe, instr_now}, {1'b0, `INSTR_IDCODE});
        conclude();
    end
endmodule : tb
`default_nettype wire
